// File: design/pesgc_bank.sv
// Purpose: event status and general configuration registers of the phy
// Assumes: core event inputs are on core_clk; interrupt enables come from outside
// Notes:   read data valid one cycle after the read strobe
`timescale 1ns/1ns

module pesgc_bank
	import pesgc_pkg::*;
#(
	parameter int unsigned ADDR_W = 5
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [15:0]       reg_rdata,
	// pulse events from the core
	input  wire logic              neg_fault_evt,
	input  wire logic              page_rx_evt,
	input  wire logic              neg_done_evt,
	input  wire logic              bogus_carrier_evt,
	input  wire logic              converter_fault_evt,
	input  wire logic              downshift_evt,
	input  wire logic              jabber_evt,
	// level states watched for change
	input  wire logic [1:0]        link_speed,
	input  wire logic              full_duplex,
	input  wire logic              link_up,
	input  wire logic              pair_swapped,
	input  wire logic              doze_active,
	input  wire logic              rx_polarity,
	// live indications
	input  wire logic              energy_efficient_fault_flag,
	input  wire logic              wake_packet_flag,
	input  wire logic              mac_buffer_fault_flag,
	// interrupt
	input  wire logic [15:0]       event_int_enable,
	output logic                   irq_pin,
	// powered device probe
	input  wire logic              pd_probe_done,
	output logic                   powered_device_probe_enable,
	// serial mac controls
	output logic                   serial_mac_tx_error_suppress,
	output logic                   serial_mac_soft_reset,
	output logic                   serial_mac_negotiation_enable,
	// downshift controls
	output logic      [3:0]        downshift_retry_limit,
	output logic                   downshift_enable,
	output logic                   downshift_energy_mode,
	output logic                   downshift_to_ten_enable,
	input  wire logic              cd_energy_seen,
	output logic                   downshift_no_cd_energy,
	// gigabit transmit clock choice
	output logic                   gtx_clk_2m5_sel,
	output logic                   gtx_clk_25m_sel,
	output logic                   gtx_clk_off,
	// collision
	input  wire logic              col_raw,
	output logic                   col_out,
	// gigabit pcs options
	output logic                   legacy_scrambler_auto_select,
	output logic                   master_semi_cross_enable,
	output logic                   slave_semi_cross_enable
);
	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W < ADDR_W_MIN) begin : g_bad_addr
		$error("address too narrow for register offsets");
	end

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] off);
		hit = (a == ADDR_W'(off));
	endfunction : hit

	// attempt count is a power of two of the field
	function automatic logic [3:0] retry_count(input logic [1:0] code);
		retry_count = 4'(4'h1 << code);
	endfunction : retry_count

	// ----------------------------------------------------------------
	// carrier and leaves
	// ----------------------------------------------------------------
	pesgc_core_if core ();

	pesgc_event_latch u_latch (
		.core_clk (core_clk),
		.rst      (rst),
		.core     (core.latch)
	);

	pesgc_cfg_reg u_cfg (
		.core_clk (core_clk),
		.rst      (rst),
		.core     (core.cfg)
	);

	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	logic status_rd;
	logic cfg_rd;
	logic cfg_wr;

	always_comb begin
		status_rd = 1'b0;
		cfg_rd    = 1'b0;
		cfg_wr    = 1'b0;
		if (hit(reg_addr, OFF_EVENT_STATUS)) begin
			status_rd = reg_rd;
		end else if (hit(reg_addr, OFF_GEN_CFG_TWO)) begin
			cfg_rd = reg_rd;
			cfg_wr = reg_wr;
		end
	end

	// ----------------------------------------------------------------
	// change detection on level states
	// ----------------------------------------------------------------
	// first sample after reset only arms, so reset release gives no false change
	logic       armed_q;
	logic [1:0] speed_q;
	logic       duplex_q;
	logic       link_q;
	logic       swap_q;
	logic       doze_q;
	logic       pol_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			speed_q  <= 2'h0;
			duplex_q <= 1'b0;
			link_q   <= 1'b0;
			swap_q   <= 1'b0;
			doze_q   <= 1'b0;
			pol_q    <= 1'b0;
		end else begin
			speed_q  <= link_speed;
			duplex_q <= full_duplex;
			link_q   <= link_up;
			swap_q   <= pair_swapped;
			doze_q   <= doze_active;
			pol_q    <= rx_polarity;
		end
	end

	logic rate_chg;
	logic duplex_chg;
	logic link_chg;
	logic swap_chg;
	logic doze_chg;
	logic pol_chg;

	assign rate_chg   = armed_q & (speed_q != link_speed);
	assign duplex_chg = armed_q & (duplex_q != full_duplex);
	assign link_chg   = armed_q & (link_q != link_up);
	assign swap_chg   = armed_q & (swap_q != pair_swapped);
	assign doze_chg   = armed_q & (doze_q != doze_active);
	assign pol_chg    = armed_q & (pol_q != rx_polarity);

	// ----------------------------------------------------------------
	// event vector into the latches
	// ----------------------------------------------------------------
	// no enable term here: masking acts on the interrupt only
	always_comb begin
		core.evt                   = ZERO_WORD;
		core.evt[EV_NEG_FAULT]     = neg_fault_evt;
		core.evt[EV_PAGE]          = page_rx_evt;
		core.evt[EV_NEG_DONE]      = neg_done_evt;
		core.evt[EV_RATE]          = rate_chg;
		core.evt[EV_DUPLEX]        = duplex_chg;
		core.evt[EV_LINK]          = link_chg;
		core.evt[EV_BOGUS_CARRIER] = bogus_carrier_evt;
		core.evt[EV_CONVERTER]     = converter_fault_evt;
		core.evt[EV_PAIR_SWAP]     = swap_chg;
		core.evt[EV_DOWNSHIFT]     = downshift_evt;
		core.evt[EV_DOZE]          = doze_chg;
		core.evt[EV_POLARITY]      = pol_chg;
		core.evt[EV_JABBER]        = jabber_evt;
	end

	// a read clears exactly what it returns
	assign core.clr = status_rd ? core.flags : ZERO_WORD;

	// ----------------------------------------------------------------
	// live bits beside the latched ones
	// ----------------------------------------------------------------
	logic [15:0] live;
	logic [15:0] status_word;

	always_comb begin
		live                = ZERO_WORD;
		live[EV_EEE]        = energy_efficient_fault_flag;
		live[EV_WAKE]       = wake_packet_flag;
		// mac buffer indication is known to be unreliable; software should not trust it
		live[EV_MAC_BUFFER] = mac_buffer_fault_flag;
	end

	assign status_word = (core.flags & LATCH_MASK) | (live & LIVE_MASK);

	// ----------------------------------------------------------------
	// configuration write path
	// ----------------------------------------------------------------
	assign core.cfg_wr    = cfg_wr;
	assign core.cfg_wdata = reg_wdata;
	assign core.pd_done   = pd_probe_done;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	logic [15:0] rdata_q;

	// unmapped addresses and idle cycles read zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= ZERO_WORD;
		end else if (status_rd) begin
			rdata_q <= status_word;
		end else if (cfg_rd) begin
			rdata_q <= core.cfg_q;
		end else begin
			rdata_q <= ZERO_WORD;
		end
	end

	assign reg_rdata = rdata_q;

	// ----------------------------------------------------------------
	// interrupt pin
	// ----------------------------------------------------------------
	logic irq_active;
	logic irq_q;

	assign irq_active = |(status_word & event_int_enable);

	// idle level follows the reset polarity so the pin is quiet from reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_q <= CFG_RESET[CF_IRQ_LOW];
		end else begin
			irq_q <= irq_active ^ core.cfg_q[CF_IRQ_LOW];
		end
	end

	assign irq_pin = irq_q;

	// ----------------------------------------------------------------
	// configuration outputs
	// ----------------------------------------------------------------
	logic [3:0] retry_q;
	logic       clk_2m5_q;
	logic       clk_25m_q;
	logic       clk_off_q;
	logic       no_cd_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			retry_q <= retry_count(CFG_RESET[CF_RETRY_HI:CF_RETRY_LO]);
		end else begin
			retry_q <= retry_count(core.cfg_q[CF_RETRY_HI:CF_RETRY_LO]);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			clk_2m5_q <= 1'b1;
			clk_25m_q <= 1'b0;
			clk_off_q <= 1'b0;
		end else begin
			clk_2m5_q <= core.cfg_q[CF_CLK_HI:CF_CLK_LO] == CLK_SEL_2M5;
			clk_25m_q <= core.cfg_q[CF_CLK_HI:CF_CLK_LO] == CLK_SEL_25M;
			clk_off_q <= core.cfg_q[CF_CLK_HI];
		end
	end

	// enhanced mode only counts when downshift itself is on
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			no_cd_q <= 1'b0;
		end else begin
			no_cd_q <= core.cfg_q[CF_DS_EN] & core.cfg_q[CF_DS_ENERGY] & ~cd_energy_seen;
		end
	end

	assign powered_device_probe_enable   = core.cfg_q[CF_PD_PROBE];
	assign serial_mac_tx_error_suppress  = core.cfg_q[CF_TX_ERR_SUPP];
	assign serial_mac_soft_reset         = core.soft_rst;
	assign serial_mac_negotiation_enable = core.cfg_q[CF_NEG_EN];
	assign downshift_retry_limit         = retry_q;
	assign downshift_enable              = core.cfg_q[CF_DS_EN];
	assign downshift_energy_mode         = core.cfg_q[CF_DS_ENERGY];
	assign downshift_to_ten_enable       = core.cfg_q[CF_DS_TEN];
	assign downshift_no_cd_energy        = no_cd_q;
	assign gtx_clk_2m5_sel               = clk_2m5_q;
	assign gtx_clk_25m_sel               = clk_25m_q;
	assign gtx_clk_off                   = clk_off_q;
	assign legacy_scrambler_auto_select  = core.cfg_q[CF_LEGACY_SCR];
	assign master_semi_cross_enable      = core.cfg_q[CF_MASTER_SEMI];
	assign slave_semi_cross_enable       = core.cfg_q[CF_SLAVE_SEMI];

	// ----------------------------------------------------------------
	// collision gating
	// ----------------------------------------------------------------
	// one cycle of latency traded for a flopped output
	logic col_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			col_q <= 1'b0;
		end else begin
			col_q <= col_raw & (~full_duplex | core.cfg_q[CF_COL_FD]);
		end
	end

	assign col_out = col_q;
endmodule : pesgc_bank

// File: design/pesgc_pkg.sv
// Purpose: shared constants of the event status and general configuration bank
// Assumes: 16-bit management registers at their printed offsets
// Notes:   bit positions are shared by the top and both leaf modules
package pesgc_pkg;
	// ----------------------------------------------------------------
	// bus shape and offsets
	// ----------------------------------------------------------------
	localparam int unsigned   DATA_W           = 16;
	localparam int unsigned   ADDR_W_MIN       = 5;
	localparam logic [4:0]    OFF_EVENT_STATUS = 5'h13;
	localparam logic [4:0]    OFF_GEN_CFG_TWO  = 5'h14;
	// ----------------------------------------------------------------
	// reset values and bit classes
	// ----------------------------------------------------------------
	localparam logic [15:0]   EVENT_RESET      = 16'h0000;
	localparam logic [15:0]   CFG_RESET        = 16'h29c7;
	localparam logic [15:0]   LATCH_MASK       = 16'hfdf3;
	localparam logic [15:0]   LIVE_MASK        = 16'h020c;
	localparam logic [15:0]   ZERO_WORD        = 16'h0000;
	// ----------------------------------------------------------------
	// event status bit positions
	// ----------------------------------------------------------------
	localparam int unsigned   EV_NEG_FAULT     = 15;
	localparam int unsigned   EV_RATE          = 14;
	localparam int unsigned   EV_DUPLEX        = 13;
	localparam int unsigned   EV_PAGE          = 12;
	localparam int unsigned   EV_NEG_DONE      = 11;
	localparam int unsigned   EV_LINK          = 10;
	localparam int unsigned   EV_EEE           = 9;
	localparam int unsigned   EV_BOGUS_CARRIER = 8;
	localparam int unsigned   EV_CONVERTER     = 7;
	localparam int unsigned   EV_PAIR_SWAP     = 6;
	localparam int unsigned   EV_DOWNSHIFT     = 5;
	localparam int unsigned   EV_DOZE          = 4;
	localparam int unsigned   EV_WAKE          = 3;
	localparam int unsigned   EV_MAC_BUFFER    = 2;
	localparam int unsigned   EV_POLARITY      = 1;
	localparam int unsigned   EV_JABBER        = 0;
	// ----------------------------------------------------------------
	// configuration bit positions
	// ----------------------------------------------------------------
	localparam int unsigned   CF_PD_PROBE      = 15;
	localparam int unsigned   CF_TX_ERR_SUPP   = 14;
	localparam int unsigned   CF_IRQ_LOW       = 13;
	localparam int unsigned   CF_SOFT_RESET    = 12;
	localparam int unsigned   CF_RETRY_HI      = 11;
	localparam int unsigned   CF_RETRY_LO      = 10;
	localparam int unsigned   CF_DS_EN         = 9;
	localparam int unsigned   CF_DS_ENERGY     = 8;
	localparam int unsigned   CF_NEG_EN        = 7;
	localparam int unsigned   CF_DS_TEN        = 6;
	localparam int unsigned   CF_CLK_HI        = 5;
	localparam int unsigned   CF_CLK_LO        = 4;
	localparam int unsigned   CF_COL_FD        = 3;
	localparam int unsigned   CF_LEGACY_SCR    = 2;
	localparam int unsigned   CF_MASTER_SEMI   = 1;
	localparam int unsigned   CF_SLAVE_SEMI    = 0;
	// ----------------------------------------------------------------
	// field codes
	// ----------------------------------------------------------------
	localparam logic [1:0]    CLK_SEL_2M5      = 2'h0;
	localparam logic [1:0]    CLK_SEL_25M      = 2'h1;
endpackage : pesgc_pkg

// File: design/pesgc_core_if.sv
// Purpose: carrier between the bank top and its latch and config leaves
// Assumes: all signals on core_clk
// Notes:   top drives requests, leaves return stored state
`timescale 1ns/1ns
interface pesgc_core_if;
	import pesgc_pkg::*;
	logic [DATA_W-1:0] evt;
	logic [DATA_W-1:0] clr;
	logic [DATA_W-1:0] flags;
	logic              cfg_wr;
	logic [DATA_W-1:0] cfg_wdata;
	logic [DATA_W-1:0] cfg_q;
	logic              pd_done;
	logic              soft_rst;
	modport top   (output evt, clr, cfg_wr, cfg_wdata, pd_done,
	               input flags, cfg_q, soft_rst);
	modport latch (input evt, clr, output flags);
	modport cfg   (input cfg_wr, cfg_wdata, pd_done, output cfg_q, soft_rst);
endinterface : pesgc_core_if

// File: design/pesgc_event_latch.sv
// Purpose: latched-high, clear-on-read event flags
// Assumes: clr holds only flags returned by the read in this cycle
// Notes:   non-latched positions stay zero here
`timescale 1ns/1ns
module pesgc_event_latch
	import pesgc_pkg::*;
(
	// clock and reset
	input  wire logic   core_clk,
	input  wire logic   rst,
	// carrier
	pesgc_core_if.latch core
);
	// ----------------------------------------------------------------
	// one latch per event bit set in LATCH_MASK; live positions get none
	// ----------------------------------------------------------------
	for (genvar i = 0; i < DATA_W; i++) begin : g_flag
		if (LATCH_MASK[i]) begin : g_latched
			logic flag_q;
			// set beats clear so a same-cycle event is kept
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					flag_q <= EVENT_RESET[i];
				end else begin
					flag_q <= (flag_q & ~core.clr[i]) | core.evt[i];
				end
			end
			assign core.flags[i] = flag_q;
		end else begin : g_live
			assign core.flags[i] = 1'b0;
		end
	end
endmodule : pesgc_event_latch

// File: design/pesgc_cfg_reg.sv
// Purpose: general configuration register with self-clearing controls
// Assumes: pd_done is a one-cycle pulse from the detection engine
// Notes:   a write in the same cycle as pd_done wins
`timescale 1ns/1ns
module pesgc_cfg_reg
	import pesgc_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// carrier
	pesgc_core_if.cfg core
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] cfg_q;
	logic [DATA_W-1:0] cfg_d;
	logic              soft_q;

	always_comb begin
		cfg_d = cfg_q;
		if (core.pd_done) begin
			cfg_d[CF_PD_PROBE] = 1'b0;
		end
		if (core.cfg_wr) begin
			cfg_d = core.cfg_wdata;
		end
		cfg_d[CF_SOFT_RESET] = 1'b0;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_q <= CFG_RESET;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// single pulse per write of one
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			soft_q <= 1'b0;
		end else begin
			soft_q <= core.cfg_wr & core.cfg_wdata[CF_SOFT_RESET];
		end
	end

	assign core.cfg_q    = cfg_q;
	assign core.soft_rst = soft_q;
endmodule : pesgc_cfg_reg

// File: sim/pesgc_bank_asserts.sv
// Purpose: port-level checks of the event status and config bank
// Assumes: one core_clk domain, rst async active high
// Notes:   flags are visible only through status reads
`timescale 1ns/1ns
module pesgc_bank_asserts
	import pesgc_pkg::*;
#(
	parameter int unsigned ADDR_W = 5
) (
	// clock and reset
	input wire logic              core_clk,
	input wire logic              rst,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [15:0]       reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [15:0]       reg_rdata,
	// core side inputs
	input wire logic              neg_fault_evt,
	input wire logic              jabber_evt,
	input wire logic              energy_efficient_fault_flag,
	input wire logic              wake_packet_flag,
	input wire logic              mac_buffer_fault_flag,
	input wire logic              full_duplex,
	input wire logic              col_raw,
	input wire logic              pd_probe_done,
	// outputs
	input wire logic              col_out,
	input wire logic              powered_device_probe_enable,
	input wire logic              serial_mac_soft_reset,
	input wire logic [3:0]        downshift_retry_limit,
	input wire logic              gtx_clk_off,
	input wire logic              gtx_clk_25m_sel
);
	// ----
	// helpers
	// ----
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic       rd_st;
	logic       wr_cf;
	logic [1:0] clk_code;
	logic [1:0] retry_code;
	assign rd_st      = reg_rd && (reg_addr == ADDR_W'(OFF_EVENT_STATUS));
	assign wr_cf      = reg_wr && (reg_addr == ADDR_W'(OFF_GEN_CFG_TWO));
	assign clk_code   = reg_wdata[5:4];
	assign retry_code = reg_wdata[11:10];
	// ----
	// properties
	// ----
	property p_neg_fault; neg_fault_evt ##1 rd_st |=> reg_rdata[EV_NEG_FAULT]; endproperty
	a_neg_fault: assert property (p_neg_fault) else $error("fault flag lost");
	property p_jabber; jabber_evt ##1 rd_st |=> reg_rdata[EV_JABBER]; endproperty
	a_jabber: assert property (p_jabber) else $error("jabber flag lost");
	property p_clear;
		(rd_st && !jabber_evt) ##1 !jabber_evt ##1 (rd_st && !jabber_evt) |=> !reg_rdata[0];
	endproperty
	a_clear: assert property (p_clear) else $error("flag kept after read");
	property p_keep;
		(rd_st && jabber_evt) ##1 !rd_st ##1 rd_st |=> reg_rdata[EV_JABBER];
	endproperty
	a_keep: assert property (p_keep) else $error("same cycle event dropped");
	property p_live;
		rd_st |=> reg_rdata[9] == $past(energy_efficient_fault_flag) &&
			reg_rdata[3] == $past(wake_packet_flag) && reg_rdata[2] == $past(mac_buffer_fault_flag);
	endproperty
	a_live: assert property (p_live) else $error("live bit mismatch");
	property p_soft;
		wr_cf && reg_wdata[12] |=> serial_mac_soft_reset ##1
			(!serial_mac_soft_reset || $past(wr_cf && reg_wdata[12]));
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset pulse wrong");
	property p_pd; pd_probe_done && !wr_cf |=> !powered_device_probe_enable; endproperty
	a_pd: assert property (p_pd) else $error("probe enable not cleared");
	property p_retry; wr_cf |=> ##1 downshift_retry_limit == 4'(4'h1 << $past(retry_code, 2)); endproperty
	a_retry: assert property (p_retry) else $error("retry limit wrong");
	property p_gtx;
		wr_cf |=> ##1 gtx_clk_off == $past(clk_code[1], 2) && gtx_clk_25m_sel == ($past(clk_code, 2) == 2'h1);
	endproperty
	a_gtx: assert property (p_gtx) else $error("clock select wrong");
	property p_col; !full_duplex |=> col_out == $past(col_raw); endproperty
	a_col: assert property (p_col) else $error("half duplex collision wrong");
	c_jabber: cover property (rd_st ##1 reg_rdata[EV_JABBER]);
	c_soft: cover property (wr_cf && reg_wdata[12]);
	c_pd: cover property (pd_probe_done ##1 !powered_device_probe_enable);
endmodule : pesgc_bank_asserts
bind pesgc_bank pesgc_bank_asserts #(.ADDR_W(ADDR_W)) u_pesgc_bank_asserts (.*);

// File: sim/tb_pesgc_bank.sv
// Purpose: self-checking bench for the event status and config bank
// Assumes: read data one cycle after strobe, no bus waits
// Notes:   fixed latencies, so waits are fixed counts
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_errors++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb_pesgc_bank;
	import pesgc_pkg::*;
	// ----
	// signals
	// ----
	logic core_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, event_int_enable = 16'h0000, rv;
	logic neg_fault_evt = 1'h0, page_rx_evt = 1'h0, neg_done_evt = 1'h0, bogus_carrier_evt = 1'h0;
	logic converter_fault_evt = 1'h0, downshift_evt = 1'h0, jabber_evt = 1'h0;
	logic [1:0] link_speed = 2'h0;
	logic full_duplex = 1'h0, link_up = 1'h0, pair_swapped = 1'h0, doze_active = 1'h0;
	logic rx_polarity = 1'h0, energy_efficient_fault_flag = 1'h0, wake_packet_flag = 1'h0;
	logic mac_buffer_fault_flag = 1'h0, pd_probe_done = 1'h0, cd_energy_seen = 1'h0, col_raw = 1'h0;
	logic irq_pin, powered_device_probe_enable, serial_mac_tx_error_suppress, serial_mac_soft_reset;
	logic serial_mac_negotiation_enable, downshift_enable, downshift_energy_mode;
	logic downshift_to_ten_enable, downshift_no_cd_energy, gtx_clk_2m5_sel, gtx_clk_25m_sel;
	logic [3:0] downshift_retry_limit;
	logic gtx_clk_off, col_out, legacy_scrambler_auto_select;
	logic master_semi_cross_enable, slave_semi_cross_enable;
	int n_errors = 0;
	int num_checks = 0;
	logic [15:0] tw [4] = '{16'h4308, 16'hc5b4, 16'h0b23, 16'h4e5b};
	pesgc_bank #(.ADDR_W(5)) u_pesgc_bank (.*);
	always #4 core_clk = ~core_clk;
	// ----
	// bus and check tasks
	// ----
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask : wr
	task automatic chk_rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge core_clk);
		{reg_rd, reg_addr} <= {1'h1, a};
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1 `CHK("rdata", e, reg_rdata)
	endtask : chk_rd
	task automatic chk_outs(input logic [15:0] w);
		`CHK("cfg outs", {w[15:14], w[9:6], w[2:0]}, {powered_device_probe_enable,
			serial_mac_tx_error_suppress, downshift_enable, downshift_energy_mode,
			serial_mac_negotiation_enable, downshift_to_ten_enable, legacy_scrambler_auto_select,
			master_semi_cross_enable, slave_semi_cross_enable})
	endtask : chk_outs
	task automatic conclude();
		if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	// ----
	// scenarios
	// ----
	task automatic t_events();
		@(posedge core_clk);
		{neg_fault_evt, page_rx_evt, neg_done_evt, bogus_carrier_evt} <= 4'hf;
		{converter_fault_evt, downshift_evt, jabber_evt, link_speed} <= 5'h1e;
		{full_duplex, link_up, pair_swapped, doze_active, rx_polarity} <= 5'h1f;
		@(posedge core_clk);
		{neg_fault_evt, page_rx_evt, neg_done_evt, bogus_carrier_evt} <= 4'h0;
		{converter_fault_evt, downshift_evt, jabber_evt, reg_rd, reg_addr} <= 9'h033;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1 `CHK("status", 16'hfdf3, reg_rdata)
		`CHK("irq masked", 1'h1, irq_pin)
		chk_rd(5'h13, 16'h0000);
		{energy_efficient_fault_flag, wake_packet_flag, mac_buffer_fault_flag} <= 3'h7;
		chk_rd(5'h13, 16'h020c);
		{energy_efficient_fault_flag, wake_packet_flag, mac_buffer_fault_flag} <= 3'h0;
		chk_rd(5'h13, 16'h0000);
	endtask : t_events
	task automatic t_same_and_irq();
		@(posedge core_clk);
		{reg_rd, reg_addr, jabber_evt, event_int_enable} <= {1'h1, 5'h13, 1'h1, 16'h0001};
		@(posedge core_clk);
		{reg_rd, jabber_evt} <= 2'h0;
		#1 `CHK("same cycle", 16'h0000, reg_rdata)
		repeat (2) @(posedge core_clk);
		#1 `CHK("irq low", 1'h0, irq_pin)
		wr(5'h14, 16'h09c7);
		repeat (2) @(posedge core_clk);
		#1 `CHK("irq high", 1'h1, irq_pin)
		chk_rd(5'h13, 16'h0001);
		repeat (2) @(posedge core_clk);
		#1 `CHK("irq idle", 1'h0, irq_pin)
		// read with event, idle cycle, read again: event must survive
		@(posedge core_clk);
		{reg_rd, reg_addr, jabber_evt} <= {1'h1, 5'h13, 1'h1};
		@(posedge core_clk);
		{reg_rd, jabber_evt} <= 2'h0;
		#1 `CHK("same cycle 2", 16'h0000, reg_rdata)
		chk_rd(5'h13, 16'h0001);
	endtask : t_same_and_irq
	task automatic t_cfg();
		for (int i = 0; i < 4; i++) begin
			cd_energy_seen <= i[1];
			wr(5'h14, tw[i]);
			#1 chk_outs(tw[i]);
			@(posedge core_clk);
			#1 `CHK("retry", 4'(4'h1 << tw[i][11:10]), downshift_retry_limit)
			`CHK("clk", {tw[i][5:4] == 2'h0, tw[i][5:4] == 2'h1, tw[i][5]},
				{gtx_clk_2m5_sel, gtx_clk_25m_sel, gtx_clk_off})
			`CHK("no cd", tw[i][9] & tw[i][8] & ~i[1], downshift_no_cd_energy)
			chk_rd(5'h14, tw[i]);
		end
		wr(5'h14, 16'h8000);
		pd_probe_done <= 1'h1;
		@(posedge core_clk);
		pd_probe_done <= 1'h0;
		#1 `CHK("probe", 1'h0, powered_device_probe_enable)
		wr(5'h14, 16'h1000);
		#1 `CHK("soft rst", 1'h1, serial_mac_soft_reset)
		@(posedge core_clk);
		#1 `CHK("soft rst end", 1'h0, serial_mac_soft_reset)
		chk_rd(5'h14, 16'h0000);
		col_raw <= 1'h1;
		repeat (2) @(posedge core_clk);
		#1 `CHK("col fd off", 1'h0, col_out)
		wr(5'h14, 16'h0008);
		@(posedge core_clk);
		#1 `CHK("col fd on", 1'h1, col_out)
		wr(5'h13, 16'hffff);
		wr(5'h15, 16'hffff);
		chk_rd(5'h13, 16'h0000);
		chk_rd(5'h15, 16'h0000);
		chk_rd(5'h14, 16'h0008);
		// half duplex passes collision even with the full duplex enable off
		{full_duplex, col_raw} <= 2'h1;
		wr(5'h14, 16'h0000);
		@(posedge core_clk);
		#1 `CHK("col hd", 1'h1, col_out)
	endtask : t_cfg
	initial begin
		repeat (5000) @(posedge core_clk);
		n_errors++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'h0;
		#1 `CHK("irq rst", 1'h1, irq_pin)
		`CHK("retry rst", 4'h4, downshift_retry_limit)
		`CHK("clk rst", 3'h4, {gtx_clk_2m5_sel, gtx_clk_25m_sel, gtx_clk_off})
		chk_outs(16'h29c7);
		chk_rd(5'h14, 16'h29c7);
		chk_rd(5'h13, 16'h0000);
		t_events();
		t_same_and_irq();
		t_cfg();
		conclude();
	end
endmodule : tb_pesgc_bank
